// ===== tdim_consts.vh
// Purpose: constants shared by the transfer descriptor done interrupt block
// Assumes: byte offsets on an 8-bit register address
// Notes:   field positions are bit indices in the 16-bit registers
`ifndef TDIM_CONSTS_VH
`define TDIM_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define TDIM_OFS_SCHED_CTL    8'hce
`define TDIM_OFS_LATENCY      8'hd0
`define TDIM_OFS_IRQ_CLEAR    8'hd2
`define TDIM_OFS_IRQ_STATUS   8'hd4
`define TDIM_OFS_IRQ_ENABLE   8'hd6
`define TDIM_OFS_ISO_ANY      8'hd8
`define TDIM_OFS_PER_ANY      8'hda
`define TDIM_OFS_ASY_ANY      8'hdc
`define TDIM_OFS_ISO_ALL      8'hde
`define TDIM_OFS_PER_ALL      8'he0
`define TDIM_OFS_ASY_ALL      8'he2

// ****************************************************************
// field positions (status, clear and enable share one layout)
// ****************************************************************
`define TDIM_BIT_ISO          9
`define TDIM_BIT_ASY          8
`define TDIM_BIT_PER          7
`define TDIM_BIT_SOF          1
`define TDIM_BIT_SCHED_EN     0

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define TDIM_MASK_RST         16'h0000
`define TDIM_REG_RST          16'h0000
`define TDIM_LAT_RST          4'h0
`define TDIM_NUM_TD           16
`define TDIM_NUM_MASK         6
`define TDIM_IRQ_USED         16'h0382

// ****************************************************************
// timing
// ****************************************************************
`define TDIM_MFRAME_US        125
`define TDIM_CLK_MHZ          250
`define TDIM_MFRAME_CYC       (`TDIM_MFRAME_US * `TDIM_CLK_MHZ)

`endif

// ===== tdim_mask_mem.v
// Purpose: storage for the six 16-bit descriptor group masks
// Assumes: one write port, all words visible at once for the match logic
// Notes:   word order: iso any, periodic any, async any, iso all,
//          periodic all, async all
`timescale 1ns/10ps
`include "tdim_consts.vh"

module tdim_mask_mem (
	clk_sys,
	rst_sync_b,
	wr_en,
	wr_idx,
	wr_data,
	words
);
	input  wire         clk_sys;
	input  wire         rst_sync_b;
	input  wire         wr_en;
	input  wire [2:0]   wr_idx;
	input  wire [15:0]  wr_data;
	output wire [95:0]  words;

	genvar g;
	generate
		for (g = 0; g < `TDIM_NUM_MASK; g = g + 1) begin : g_word
			// one register per word keeps every word to a single driver
			reg [15:0] word_r;

			always @(posedge clk_sys or negedge rst_sync_b) begin
				if (!rst_sync_b) begin
					word_r <= `TDIM_MASK_RST;
				end else if (wr_en && ({29'h0, wr_idx} == g)) begin
					word_r <= wr_data;
				end
			end
			assign words[16*g +: 16] = word_r;
		end
	endgenerate
endmodule // tdim_mask_mem

// ===== tdim_top.v
// Purpose: transfer descriptor done grouping into host interrupts
// Assumes: done bits and pass-done strobe come from logic on clk_sys
// Notes:   registers on a plain port, read data one cycle after strobe
//
// What this block does
// - An isochronous any-mask, reset zero, bit n for descriptor n, fires when any selected descriptor is done.
// - A periodic interrupt list any-mask, reset zero, fires when any selected descriptor is done.
// - An asynchronous list any-mask, reset zero, fires when any selected descriptor is done.
// - An isochronous all-mask, reset zero, fires only when every selected descriptor is done.
// - A periodic interrupt list all-mask, reset zero, fires only when every selected descriptor is done.
// - An asynchronous list all-mask, reset zero, fires only when every selected descriptor is done.
// - A clear mask bit leaves its descriptor out of that mask's group entirely.
// - Each of the three lists holds at most sixteen descriptors.
// - With scheduling on, the isochronous list runs first, then periodic, then asynchronous.
// - A descriptor counts as complete when its done bit from shared memory is set.
// - Interrupt latency is a whole number of 125 us microframes.
// - Four interrupt sources exist: isochronous, periodic, asynchronous and start-of-frame.
// - Enable bits 9, 8 and 7 gate iso, async and periodic completion onto the line.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "tdim_consts.vh"

module tdim_top (
	clk_sys,
	rst_b,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	iso_td_done,
	per_td_done,
	asy_td_done,
	list_pass_done,
	iso_schedule_queue,
	periodic_schedule_queue,
	async_schedule_queue,
	mframe_tick,
	irq
);
	parameter MFRAME_CYC = `TDIM_MFRAME_CYC;

	input  wire         clk_sys;
	input  wire         rst_b;
	input  wire [7:0]   reg_addr;
	input  wire [15:0]  reg_wdata;
	input  wire         reg_wr;
	input  wire         reg_rd;
	output reg  [15:0]  reg_rdata;
	input  wire [15:0]  iso_td_done;
	input  wire [15:0]  per_td_done;
	input  wire [15:0]  asy_td_done;
	input  wire         list_pass_done;
	output wire         iso_schedule_queue;
	output wire         periodic_schedule_queue;
	output wire         async_schedule_queue;
	output reg          mframe_tick;
	output reg          irq;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// any-result or all-result of one list; empty all-mask never matches
	function grp_hit;
		input [15:0] done;
		input [15:0] any_m;
		input [15:0] all_m;
		begin
			grp_hit = (|(done & any_m)) ||
				((|all_m) && ((done & all_m) == all_m));
		end
	endfunction

	// index of a mask word for an offset, 3'h7 when not a mask
	function [2:0] mask_idx;
		input [7:0] a;
		begin
			case (a)
			`TDIM_OFS_ISO_ANY: mask_idx = 3'h0;
			`TDIM_OFS_PER_ANY: mask_idx = 3'h1;
			`TDIM_OFS_ASY_ANY: mask_idx = 3'h2;
			`TDIM_OFS_ISO_ALL: mask_idx = 3'h3;
			`TDIM_OFS_PER_ALL: mask_idx = 3'h4;
			`TDIM_OFS_ASY_ALL: mask_idx = 3'h5;
			default:           mask_idx = 3'h7;
			endcase
		end
	endfunction

	// ****************************************************************
	// reset release
	// ****************************************************************
	reg        rst_meta_r;
	reg        rst_sync_r;
	wire       rst_sync_b;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_sync_b = rst_sync_r;

	// ****************************************************************
	// mask storage
	// ****************************************************************
	wire [2:0]  wr_idx;
	wire        mask_wr;
	wire [95:0] masks;

	assign wr_idx  = mask_idx(reg_addr);
	assign mask_wr = reg_wr && (wr_idx != 3'h7);

	tdim_mask_mem u_masks (
		.clk_sys    (clk_sys),
		.rst_sync_b (rst_sync_b),
		.wr_en      (mask_wr),
		.wr_idx     (wr_idx),
		.wr_data    (reg_wdata),
		.words      (masks)
	);

	// ****************************************************************
	// control registers
	// ****************************************************************
	reg  [15:0] irq_en_r;
	reg  [15:0] irq_stat_r;
	reg  [15:0] irq_stat_nxt;
	reg  [3:0]  lat_r;
	reg         sched_en_r;
	wire        clr_wr;

	assign clr_wr = reg_wr && (reg_addr == `TDIM_OFS_IRQ_CLEAR);

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_en_r   <= `TDIM_REG_RST;
			lat_r      <= `TDIM_LAT_RST;
			sched_en_r <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
			`TDIM_OFS_IRQ_ENABLE: begin
				irq_en_r <= reg_wdata & `TDIM_IRQ_USED;
			end
			`TDIM_OFS_LATENCY: begin
				lat_r <= reg_wdata[3:0];
			end
			`TDIM_OFS_SCHED_CTL: begin
				sched_en_r <= reg_wdata[`TDIM_BIT_SCHED_EN];
			end
			default: begin
				irq_en_r <= irq_en_r;
			end
			endcase
		end
	end

	// ****************************************************************
	// completion grouping
	// ****************************************************************
	// done bits are levels; only a rising match counts as a new event so
	// a clear is not undone by descriptors still marked done
	wire [47:0] done_all;
	wire [2:0]  hit;
	reg  [2:0]  hit_d_r;

	assign done_all = {asy_td_done, per_td_done, iso_td_done};

	genvar l;
	generate
		for (l = 0; l < 3; l = l + 1) begin : g_list
			// any-mask in words 0..2, all-mask in words 3..5
			assign hit[l] = grp_hit(done_all[16*l +: 16],
				masks[16*l +: 16], masks[16*(l+3) +: 16]);
		end
	endgenerate

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			hit_d_r <= 3'h0;
		end else begin
			hit_d_r <= hit;
		end
	end

	// ****************************************************************
	// microframe timer
	// ****************************************************************
	reg [15:0] mf_cnt_r;
	wire       mf_end;

	assign mf_end = (mf_cnt_r == MFRAME_CYC[15:0] - 16'h0001);

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mf_cnt_r    <= 16'h0000;
			mframe_tick <= 1'b0;
		end else begin
			mf_cnt_r    <= mf_end ? 16'h0000 : mf_cnt_r + 16'h0001;
			mframe_tick <= mf_end;
		end
	end

	// ****************************************************************
	// sticky status, set wins over clear
	// ****************************************************************
	reg [15:0] set_vec;

	always @* begin
		set_vec = 16'h0000;
		set_vec[`TDIM_BIT_ISO] = hit[0] & ~hit_d_r[0];
		set_vec[`TDIM_BIT_PER] = hit[1] & ~hit_d_r[1];
		set_vec[`TDIM_BIT_ASY] = hit[2] & ~hit_d_r[2];
		set_vec[`TDIM_BIT_SOF] = mframe_tick;
		irq_stat_nxt = irq_stat_r;
		if (clr_wr) begin
			irq_stat_nxt = irq_stat_r & ~reg_wdata;
		end
		irq_stat_nxt = irq_stat_nxt | set_vec;
	end

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_stat_r <= `TDIM_REG_RST;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// ****************************************************************
	// interrupt line with microframe latency
	// ****************************************************************
	// latency counts microframe ticks seen while an enabled event waits;
	// zero latency gives the line one cycle after the status bit
	reg  [3:0] lat_cnt_r;
	wire       pend;

	assign pend = |(irq_stat_r & irq_en_r);

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lat_cnt_r <= 4'h0;
			irq       <= 1'b0;
		end else begin
			if (!pend) begin
				lat_cnt_r <= 4'h0;
			end else if (mframe_tick && (lat_cnt_r != lat_r)) begin
				lat_cnt_r <= lat_cnt_r + 4'h1;
			end
			irq <= pend && (lat_cnt_r >= lat_r);
		end
	end

	// ****************************************************************
	// list execution order
	// ****************************************************************
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_ISO  = 4'b0010;
	localparam [3:0] S_PER  = 4'b0100;
	localparam [3:0] S_ASY  = 4'b1000;

	reg [3:0] st_r;
	reg [3:0] st_nxt;

	// a pass starts each microframe; a late pass is dropped, not queued
	always @* begin
		st_nxt = st_r;
		case (st_r)
		S_IDLE: begin
			if (sched_en_r && mframe_tick) begin
				st_nxt = S_ISO;
			end
		end
		S_ISO: begin
			if (list_pass_done) begin
				st_nxt = S_PER;
			end
		end
		S_PER: begin
			if (list_pass_done) begin
				st_nxt = S_ASY;
			end
		end
		S_ASY: begin
			if (list_pass_done) begin
				st_nxt = S_IDLE;
			end
		end
		default: begin
			st_nxt = S_IDLE;
		end
		endcase
		if (!sched_en_r) begin
			st_nxt = S_IDLE;
		end
	end

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_r <= S_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign iso_schedule_queue      = st_r[1];
	assign periodic_schedule_queue = st_r[2];
	assign async_schedule_queue    = st_r[3];

	// ****************************************************************
	// register read
	// ****************************************************************
	reg [15:0] rd_nxt;

	always @* begin
		case (reg_addr)
		`TDIM_OFS_SCHED_CTL:  rd_nxt = {15'h0000, sched_en_r};
		`TDIM_OFS_LATENCY:    rd_nxt = {12'h000, lat_r};
		`TDIM_OFS_IRQ_STATUS: rd_nxt = irq_stat_r;
		`TDIM_OFS_IRQ_ENABLE: rd_nxt = irq_en_r;
		`TDIM_OFS_ISO_ANY:    rd_nxt = masks[15:0];
		`TDIM_OFS_PER_ANY:    rd_nxt = masks[31:16];
		`TDIM_OFS_ASY_ANY:    rd_nxt = masks[47:32];
		`TDIM_OFS_ISO_ALL:    rd_nxt = masks[63:48];
		`TDIM_OFS_PER_ALL:    rd_nxt = masks[79:64];
		`TDIM_OFS_ASY_ALL:    rd_nxt = masks[95:80];
		default:              rd_nxt = 16'h0000;
		endcase
	end

	// data stand only in the cycle after the strobe
	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rd_nxt : 16'h0000;
		end
	end
endmodule // tdim_top

// ===== tdim_top_assertions.sv
// Purpose: port-level checks for the descriptor done interrupt block
// Assumes: one clock; shadows follow what software writes
// Notes:   bound onto tdim_top, sees only its ports
`timescale 1ns/10ps

module tdim_chk #(
	parameter MFRAME_CYC = 50
) (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] iso_td_done,
	input wire logic [15:0] per_td_done,
	input wire logic [15:0] asy_td_done,
	input wire logic        list_pass_done,
	input wire logic        iso_schedule_queue,
	input wire logic        periodic_schedule_queue,
	input wire logic        async_schedule_queue,
	input wire logic        mframe_tick,
	input wire logic        irq
);
	// ****************************************************************
	// shadows of the writable registers
	// ****************************************************************
	reg  [15:0] shm [0:5];
	reg  [15:0] en_sh;
	reg  [3:0]  lat_sh;
	reg  [2:0]  hit_q;
	reg  [15:0] cnt;
	reg         seen;
	wire [7:0]  off = reg_addr - 8'hd8;
	wire        is_m = !off[0] && off < 8'h0c;
	wire [15:0] m_exp = shm[off[3:1]];
	wire [2:0]  en3 = {en_sh[8], en_sh[7], en_sh[9]};
	wire [2:0]  hit;
	integer     i;

	function automatic logic hitf(input [15:0] d, input [15:0] a,
		input [15:0] al);
		hitf = |(d & a) || (al != 16'h0000 && (d & al) == al);
	endfunction

	assign hit = {hitf(asy_td_done, shm[2], shm[5]),
		hitf(per_td_done, shm[1], shm[4]),
		hitf(iso_td_done, shm[0], shm[3])};

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 6; i = i + 1)
				shm[i] <= 16'h0000;
			en_sh <= 16'h0000;
			lat_sh <= 4'h0;
			hit_q <= 3'h0;
			cnt <= 16'h0000;
			seen <= 1'b0;
		end else begin
			if (reg_wr && is_m)
				shm[off[3:1]] <= reg_wdata;
			if (reg_wr && reg_addr == 8'hd6)
				en_sh <= reg_wdata & 16'h0382;
			if (reg_wr && reg_addr == 8'hd0)
				lat_sh <= reg_wdata[3:0];
			hit_q <= hit;
			cnt <= mframe_tick ? 16'h0000 : cnt + 16'h0001;
			seen <= seen | mframe_tick;
		end
	end

	AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
	AST_MASK_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_rd && is_m |=> reg_rdata == $past(m_exp)) else $error("mask readback");
	AST_MFRAME: assert property (@(posedge clk_sys) disable iff (!rst_b)
		mframe_tick && seen |-> cnt == 16'(MFRAME_CYC - 1))
		else $error("tick period");
	AST_ONE_LIST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$onehot0({iso_schedule_queue, periodic_schedule_queue,
		async_schedule_queue})) else $error("two lists active");
	AST_PER_AFTER_ISO: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(periodic_schedule_queue) |-> $past(iso_schedule_queue))
		else $error("periodic not after iso");
	AST_ASY_AFTER_PER: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(async_schedule_queue) |-> $past(periodic_schedule_queue))
		else $error("async not after periodic");
	AST_ISO_ON_TICK: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(iso_schedule_queue) |-> $past(mframe_tick))
		else $error("iso pass without tick");
	AST_IRQ_HIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		|(hit & ~hit_q & en3) && lat_sh == 4'h0 |-> ##2 irq)
		else $error("group hit gave no irq");
	AST_IRQ_EN: assert property (@(posedge clk_sys) disable iff (!rst_b)
		{en_sh[9:7], en_sh[1]} == 4'h0 |=> !irq) else $error("irq while disabled");
	AST_LAT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(irq) && lat_sh != 4'h0 |-> $past(mframe_tick, 2))
		else $error("delayed irq off tick");
endmodule // tdim_chk

bind tdim_top tdim_chk #(.MFRAME_CYC(MFRAME_CYC)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .iso_td_done(iso_td_done),
	.per_td_done(per_td_done), .asy_td_done(asy_td_done),
	.list_pass_done(list_pass_done), .iso_schedule_queue(iso_schedule_queue),
	.periodic_schedule_queue(periodic_schedule_queue),
	.async_schedule_queue(async_schedule_queue),
	.mframe_tick(mframe_tick), .irq(irq));

// ===== tb_tdim_top.sv
// Purpose: self-checking bench for the descriptor done interrupt block
// Assumes: microframe shortened to 50 cycles
// Notes:   expectations come from a small group-match model
`timescale 1ns/10ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
	fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end

module tb_tdim_top;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        list_pass_done = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] dn [0:2] = '{default: 16'h0000};
	logic [15:0] en_m = 16'h0000;
	logic [15:0] v;
	wire  [15:0] reg_rdata;
	wire         iso_q, per_q, asy_q, mframe_tick, irq;
	int          fail_count = 0;
	int          num_checks = 0;
	int          sb [0:2] = '{9, 7, 8};
	int          b, c, n, k;

	always #2 clk_sys = ~clk_sys;

	tdim_top #(.MFRAME_CYC(50)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .iso_td_done(dn[0]),
		.per_td_done(dn[1]), .asy_td_done(dn[2]),
		.list_pass_done(list_pass_done), .iso_schedule_queue(iso_q),
		.periodic_schedule_queue(per_q), .async_schedule_queue(asy_q),
		.mframe_tick(mframe_tick), .irq(irq));

	// ****************************************************************
	// bus tasks and model
	// ****************************************************************
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a == 8'hd6)
			en_m = d;
	endtask

	task chk_rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK("rdata", e, reg_rdata & m)
	endtask

	function automatic logic hit(input logic [15:0] d, a, al);
		return |(d & a) || (al != 0 && (d & al) == al);
	endfunction

	// done level is dropped first so the group match sees a fresh rise
	task trial(input int k, input logic [15:0] a, al, d);
		@(posedge clk_sys);
		dn[k] <= 16'h0000;
		wr(8'hd2, 16'hffff);
		wr(8'hd8 + 8'(2 * k), a);
		wr(8'hde + 8'(2 * k), al);
		@(posedge clk_sys);
		dn[k] <= d;
		repeat (3) @(posedge clk_sys);
		#1 `CHK("irq", hit(d, a, al) & en_m[sb[k]], irq)
		chk_rd(8'hd4, 16'h0380, hit(d, a, al) ? 16'h1 << sb[k] : 16'h0);
	endtask

	task pass;
		@(posedge clk_sys);
		list_pass_done <= 1'b1;
		@(posedge clk_sys);
		list_pass_done <= 1'b0;
		#1;
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		print_verdict;
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		n = $urandom(28);
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (k = 0; k < 11; k++)
			chk_rd(8'hce + 8'(2 * k), 16'hffff, 16'h0000);
		for (k = 0; k < 6; k++) begin
			v = 16'($urandom);
			wr(8'hd8 + 8'(2 * k), v);
			chk_rd(8'hd8 + 8'(2 * k), 16'hffff, v);
		end
		wr(8'hd4, 16'hffff);
		chk_rd(8'hd4, 16'hfc7d, 16'h0000);
		chk_rd(8'hd3, 16'hffff, 16'h0000);
		chk_rd(8'he4, 16'hffff, 16'h0000);
		wr(8'hd6, 16'hffff);
		chk_rd(8'hd6, 16'hffff, 16'h0382);
		wr(8'hd2, 16'h0002);
		for (n = 0; n < 60 && !mframe_tick; n++) begin
			@(posedge clk_sys);
			#1;
		end
		chk_rd(8'hd4, 16'h0002, 16'h0002);
		`CHK("irq", 1'b1, irq)
		wr(8'hd6, 16'h0380);
		wr(8'hd0, 16'h0000);
		for (k = 0; k < 3; k++) begin
			b = $urandom % 16;
			c = (b + 1 + $urandom % 15) % 16;
			trial(k, 16'h1 << b, 16'h0, 16'h1 << b);
			trial(k, ~(16'h1 << b), 16'h0, 16'h1 << b);
			trial(k, 16'h0, (16'h1 << b) | (16'h1 << c), 16'h1 << b);
			trial(k, 16'h0, (16'h1 << b) | (16'h1 << c),
				(16'h1 << b) | (16'h1 << c));
			trial(k, 16'h0, 16'h0, 16'hffff);
		end
		wr(8'hd6, 16'h0000);
		trial(0, 16'h0001, 16'h0, 16'h0001);
		wr(8'hd6, 16'h0200);
		repeat (2) @(posedge clk_sys);
		#1 `CHK("irq", 1'b1, irq)
		wr(8'hd2, 16'h0200);
		repeat (2) @(posedge clk_sys);
		#1 `CHK("irq", 1'b0, irq)
		wr(8'hd0, 16'h0002);
		dn[0] <= 16'h0000;
		for (n = 0; n < 60 && !mframe_tick; n++) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		dn[0] <= 16'h0001;
		n = 0;
		for (b = 0; b < 300 && !irq; b++) begin
			@(posedge clk_sys);
			#1 n += int'(mframe_tick);
		end
		`CHK("ticks", 2, n)
		wr(8'hd2, 16'hffff);
		wr(8'hd0, 16'h0000);
		wr(8'hce, 16'h0001);
		for (n = 0; n < 200 && !iso_q; n++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("lists", 3'b100, {iso_q, per_q, asy_q})
		pass;
		repeat (60) @(posedge clk_sys);
		#1 `CHK("lists", 3'b010, {iso_q, per_q, asy_q})
		pass;
		`CHK("lists", 3'b001, {iso_q, per_q, asy_q})
		pass;
		`CHK("lists", 3'b000, {iso_q, per_q, asy_q})
		wr(8'hce, 16'h0000);
		print_verdict;
	end
endmodule // tb_tdim_top
